// *** drive_cfg.sv ***
// drive current configuration registers with apb slave
// assumes apb master on pclk; analog side reads the decoded settings
// one clock domain, registers reset asynchronously
//
// Notes on behaviour
// - modulation frequency from code and master clock
// - some codes offset from power of two
// - low-current register readable and writable
// - drive set by both config registers
// - impedance config change may break samples
// - resync command restores timing after changes
// - low-current fields at fixed bit positions
// - range bit low or high; low needs 001 (code also accepts 000)
// - doubler selects 1X or 2X subrange
// - load enable and four load values
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module drive_cfg
  import drive_cfg_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // decoded drive settings
  output drive_setting_t drive_setting,
  output logic combo_unsupported,
  output logic resync_pulse,
  output logic imp_cfg_changed
);

  logic [23:0] lc_cfg_reg;
  logic [23:0] imp_cfg_reg;
  logic [1:0] mstr_reg;
  logic unsup_reg;
  logic changed_reg;
  sync_state_t sync_reg;
  sync_state_t sync_next;
  drive_setting_t setting_reg;
  logic [31:0] rdata_reg;

  // access decode
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire hit_lc = paddr == LC_CFG_ADDR;
  wire hit_imp = paddr == IMP_CFG_ADDR;
  wire hit_ctrl = paddr == CTRL_ADDR;
  wire hit_stat = paddr == STATUS_ADDR;
  wire mapped = hit_lc || hit_imp || hit_ctrl || hit_stat;
  wire wr_lc = wr && hit_lc;
  wire wr_imp = wr && hit_imp;
  wire wr_ctrl = wr && hit_ctrl;
  wire resync_req = wr_ctrl && pwdata[RESYNC_BIT];

  // zero wait states, unmapped access answered with an error
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // frequency decode
  wire [3:0] fcode = imp_cfg_reg[FCODE_LSB +: 4];
  wire [2:0] dmag = imp_cfg_reg[DRV_MAG_LSB +: 3];
  logic [17:0] freq_m0;
  logic [17:0] freq_m1;
  logic [17:0] freq_m2;
  logic [17:0] freq_m3;
  wire [17:0] freq;

  // 32,768 Hz master column, offset codes kept
  always_comb begin
    case (fcode)
      4'h0: freq_m0 = 18'h20000;
      4'h1: freq_m0 = 18'h14000; // offset from power of two
      4'h2: freq_m0 = 18'h0A000;
      4'h3: freq_m0 = 18'h0471C; // offset from power of two
      4'h4: freq_m0 = 18'h02000;
      4'h5: freq_m0 = 18'h01000;
      4'h6: freq_m0 = 18'h00800;
      4'h7: freq_m0 = 18'h00400;
      4'h8: freq_m0 = 18'h00200;
      4'h9: freq_m0 = 18'h00100;
      default: freq_m0 = FREQ_FLOOR; // codes 101x and 11xx
    endcase
  end

  // first 32,000 Hz master column
  always_comb begin
    case (fcode)
      4'h0: freq_m1 = 18'h1F400;
      4'h1: freq_m1 = 18'h13880;
      4'h2: freq_m1 = 18'h09C40;
      4'h3: freq_m1 = 18'h04574;
      4'h4: freq_m1 = 18'h01F40;
      4'h5: freq_m1 = 18'h00FA0;
      4'h6: freq_m1 = 18'h007D0;
      4'h7: freq_m1 = 18'h003E8;
      4'h8: freq_m1 = 18'h001F4;
      4'h9: freq_m1 = 18'h000FA;
      default: freq_m1 = 18'h0007D; // 125 Hz floor
    endcase
  end

  // second 32,000 Hz master column
  always_comb begin
    case (fcode)
      4'h0: freq_m2 = 18'h1F400;
      4'h1: freq_m2 = 18'h13880;
      4'h2: freq_m2 = 18'h09C40;
      4'h3: freq_m2 = 18'h04574;
      4'h4: freq_m2 = 18'h01F40;
      4'h5: freq_m2 = 18'h00FA0;
      4'h6: freq_m2 = 18'h007D0;
      4'h7: freq_m2 = 18'h003E8;
      4'h8: freq_m2 = 18'h001F4;
      4'h9: freq_m2 = 18'h000FA;
      default: freq_m2 = 18'h0007D; // 125 Hz floor
    endcase
  end

  // 31,968 Hz master column, top codes offset upwards
  always_comb begin
    case (fcode)
      4'h0: freq_m3 = 18'h1F380;
      4'h1: freq_m3 = 18'h14000;
      4'h2: freq_m3 = 18'h0A000;
      4'h3: freq_m3 = 18'h0471C;
      4'h4: freq_m3 = 18'h01F38;
      4'h5: freq_m3 = 18'h00F9C;
      4'h6: freq_m3 = 18'h007CE;
      4'h7: freq_m3 = 18'h003E7;
      4'h8: freq_m3 = 18'h001F4; // rounded, not truncated
      4'h9: freq_m3 = 18'h000FA;
      default: freq_m3 = 18'h0007D; // 125 Hz floor
    endcase
  end

  // column picked by the master clock select
  assign freq = (mstr_reg == 2'h0) ? freq_m0 :
                (mstr_reg == 2'h1) ? freq_m1 :
                (mstr_reg == 2'h2) ? freq_m2 : freq_m3;

  // allowed magnitude check per frequency band
  logic mag_ok;
  always_comb begin
    if (fcode < FC_8K) begin
      mag_ok = 1'b1;
    end else if (fcode == FC_8K) begin
      mag_ok = dmag != MAG_MAX;
    end else if (fcode == FC_4K) begin
      mag_ok = dmag <= MAG_UP_TO_32;
    end else if (fcode == FC_2K) begin
      mag_ok = dmag <= MAG_UP_TO_16;
    end else begin
      mag_ok = dmag <= MAG_LOW_RANGE;
    end
  end

  // low range needs magnitude 001 or 000 (off)
  wire high_range = lc_cfg_reg[RANGE_BIT];
  wire range_ok = high_range || dmag == MAG_LOW_RANGE || dmag == MAG_OFF;

  // load value decode
  wire [1:0] load_code = lc_cfg_reg[LOAD_VAL_LSB +: 2];
  logic [10:0] load_kohm;
  always_comb begin
    case (load_code)
      2'h0: load_kohm = LOAD_KOHM_0;
      2'h1: load_kohm = LOAD_KOHM_1;
      2'h2: load_kohm = LOAD_KOHM_2;
      default: load_kohm = LOAD_KOHM_3;
    endcase
  end

  // low-current register, reserved bits kept zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lc_cfg_reg <= LC_RESET;
    end else if (wr_lc) begin
      lc_cfg_reg <= pwdata[23:0] & LC_WRITE_MASK;
    end
  end

  // impedance config copy, joint with low-current reg
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imp_cfg_reg <= IMP_RESET;
    end else if (wr_imp) begin
      imp_cfg_reg <= pwdata[23:0];
    end
  end

  // master clock select from the control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mstr_reg <= 2'h0;
    end else if (wr_ctrl) begin
      mstr_reg <= pwdata[MSTR_LSB +: 2];
    end
  end

  // change flag: set on impedance write, cleared by resync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      changed_reg <= 1'b0;
    end else if (wr_imp) begin
      changed_reg <= 1'b1;
    end else if (sync_reg == SYNC_PULSE) begin
      changed_reg <= 1'b0;
    end
  end

  // resync sequencer: one-cycle pulse per command
  always_comb begin
    case (sync_reg)
      SYNC_IDLE: sync_next = resync_req ? SYNC_PULSE : SYNC_IDLE;
      SYNC_PULSE: sync_next = resync_req ? SYNC_PULSE : SYNC_IDLE;
      default: sync_next = SYNC_IDLE;
    endcase
  end

  // resync sequencer state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= SYNC_IDLE;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // next decoded settings, taken straight from the registers
  drive_setting_t setting_next;
  always_comb begin
    setting_next.high_range = high_range;
    setting_next.doubler = lc_cfg_reg[DOUBLER_BIT];
    setting_next.load_on = lc_cfg_reg[LOAD_EN_BIT];
    setting_next.load_kohm = load_kohm;
    setting_next.cm_res = lc_cfg_reg[CMRES_LSB +: 4];
    setting_next.lc_mag = lc_cfg_reg[LC_MAG_LSB +: 4];
    setting_next.drv_mag = dmag;
    setting_next.mod_freq_hz = freq;
  end
  wire unsup_next = !(mag_ok && range_ok);

  // decoded settings register, never altered by the
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setting_reg <= '0;
    end else begin
      setting_reg <= setting_next;
    end
  end

  // unsupported flag, a level that follows the registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unsup_reg <= 1'b0;
    end else begin
      unsup_reg <= unsup_next;
    end
  end

  // status word: pulse, change flag, unsupported flag
  wire [2:0] status_bits = {resync_pulse, changed_reg, unsup_reg};
  wire rd_setup = psel && !penable && !pwrite;

  // read mux, unmapped offsets read as zero
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (hit_lc) begin
      rmux = {8'h00, lc_cfg_reg};
    end
    if (hit_imp) begin
      rmux = {8'h00, imp_cfg_reg};
    end
    if (hit_ctrl) begin
      rmux = {30'h0, mstr_reg};
    end
    if (hit_stat) begin
      rmux = {29'h0, status_bits};
    end
  end

  // read data captured in setup, stands through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      rdata_reg <= rmux;
    end
  end

  assign prdata = rdata_reg;
  assign drive_setting = setting_reg;
  assign combo_unsupported = unsup_reg;
  assign resync_pulse = sync_reg == SYNC_PULSE;
  assign imp_cfg_changed = changed_reg;

endmodule : drive_cfg

// *** drive_cfg_pkg.sv ***
// package for the drive current configuration block
// assumes an apb slave with 32-bit data and one clock
package drive_cfg_pkg;

  // register byte addresses (printed offsets are word indices)
  localparam logic [7:0] LC_CFG_IDX = 8'h1A;
  localparam logic [7:0] IMP_CFG_IDX = 8'h18;
  localparam logic [7:0] CTRL_IDX = 8'h40;
  localparam logic [7:0] STATUS_IDX = 8'h41;
  localparam logic [11:0] LC_CFG_ADDR = {2'h0, LC_CFG_IDX, 2'h0};
  localparam logic [11:0] IMP_CFG_ADDR = {2'h0, IMP_CFG_IDX, 2'h0};
  localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] STATUS_ADDR = {2'h0, STATUS_IDX, 2'h0};

  // low-current register fields
  localparam int RANGE_BIT = 23;
  localparam int DOUBLER_BIT = 19;
  localparam int LOAD_EN_BIT = 14;
  localparam int LOAD_VAL_LSB = 12;
  localparam int CMRES_LSB = 4;
  localparam int LC_MAG_LSB = 0;
  localparam logic [23:0] LC_WRITE_MASK = 24'h88_70FF;
  localparam logic [23:0] LC_RESET = 24'h00_0055;

  // impedance config fields used here
  localparam int FCODE_LSB = 8;
  localparam int DRV_MAG_LSB = 4;
  localparam logic [23:0] IMP_RESET = 24'h00_0000;

  // control register bits
  localparam int MSTR_LSB = 0;
  localparam int RESYNC_BIT = 8;

  // drive magnitude codes
  localparam logic [2:0] MAG_OFF = 3'h0;
  localparam logic [2:0] MAG_LOW_RANGE = 3'h1;
  localparam logic [2:0] MAG_MAX = 3'h7;
  localparam logic [2:0] MAG_UP_TO_32 = 3'h3;
  localparam logic [2:0] MAG_UP_TO_16 = 3'h2;

  // frequency codes
  localparam logic [3:0] FC_8K = 4'h4;
  localparam logic [3:0] FC_4K = 4'h5;
  localparam logic [3:0] FC_2K = 4'h6;
  localparam logic [3:0] FC_LAST_HALVING = 4'h9;
  localparam logic [17:0] FREQ_FLOOR = 18'd128;

  // load values in kOhm
  localparam logic [10:0] LOAD_KOHM_0 = 11'd27;
  localparam logic [10:0] LOAD_KOHM_1 = 11'd108;
  localparam logic [10:0] LOAD_KOHM_2 = 11'd487;
  localparam logic [10:0] LOAD_KOHM_3 = 11'd1029;

  // decoded drive settings carried together
  typedef struct packed {
    logic high_range;
    logic doubler;
    logic load_on;
    logic [10:0] load_kohm;
    logic [3:0] cm_res;
    logic [3:0] lc_mag;
    logic [2:0] drv_mag;
    logic [17:0] mod_freq_hz;
  } drive_setting_t;

  // resync sequencer states
  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b01,
    SYNC_PULSE = 2'b10
  } sync_state_t;

endpackage : drive_cfg_pkg

// *** drive_cfg_sva.sv ***
// checker: apb answer and flag timing of drive_cfg
// bound to every drive_cfg, one pclk domain
`timescale 1ns/1ps
module drive_cfg_sva
  import drive_cfg_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // settings
  input wire drive_setting_t drive_setting,
  input wire logic resync_pulse,
  input wire logic imp_cfg_changed
);
  // access decode
  wire acc = psel && penable;
  wire hit = paddr inside {LC_CFG_ADDR, IMP_CFG_ADDR, CTRL_ADDR,
    STATUS_ADDR};
  wire wr_sync = acc && pwrite && paddr == CTRL_ADDR && pwdata[RESYNC_BIT];
  wire wr_imp = acc && pwrite && paddr == IMP_CFG_ADDR;
  wire wr_lc = acc && pwrite && paddr == LC_CFG_ADDR;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; acc && !hit |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("no slverr");
  property p_ok; acc && hit |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("bad slverr");
  property p_sync; wr_sync |=> resync_pulse; endproperty
  a_sync: assert property (p_sync) else $error("no resync");
  property p_src; resync_pulse |-> $past(wr_sync); endproperty
  a_src: assert property (p_src) else $error("stray resync");
  property p_chg; wr_imp |=> imp_cfg_changed; endproperty
  a_chg: assert property (p_chg) else $error("no change flag");
  property p_clr; resync_pulse && !wr_imp |=> !imp_cfg_changed; endproperty
  a_clr: assert property (p_clr) else $error("flag kept");
  property p_lc;
    wr_lc |-> ##2 {drive_setting.high_range, drive_setting.doubler,
      drive_setting.load_on, drive_setting.cm_res, drive_setting.lc_mag}
      == $past({pwdata[23], pwdata[19], pwdata[14], pwdata[7:0]}, 2);
  endproperty
  a_lc: assert property (p_lc) else $error("field decode");
endmodule : drive_cfg_sva
bind drive_cfg drive_cfg_sva chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .drive_setting,
  .resync_pulse, .imp_cfg_changed);

// *** tb.sv ***
// self-checking bench for drive_cfg
// bench is the apb master, no partner model
`timescale 1ns/1ps
module tb
  import drive_cfg_pkg::*;
;
  // one row: master, code, magnitude, expected hz, flag
  typedef struct packed {
    logic [1:0] ms;
    logic [3:0] fc;
    logic [2:0] mg;
    logic [17:0] hz;
    logic bad;
  } row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, combo_unsupported, resync_pulse;
  logic imp_cfg_changed;
  drive_setting_t drive_setting;
  int fails = 0, compares = 0;
  logic [10:0] kohm [4] = '{11'h01B, 11'h06C, 11'h1E7, 11'h405};
  row_t rows [20] = '{
    '{2'h0, 4'h0, 3'h7, 18'h20000, 1'h0}, '{2'h0, 4'h3, 3'h7, 18'h0471C, 1'h0},
    '{2'h0, 4'h4, 3'h7, 18'h02000, 1'h1}, '{2'h0, 4'h4, 3'h6, 18'h02000, 1'h0},
    '{2'h1, 4'h5, 3'h3, 18'h00FA0, 1'h0}, '{2'h1, 4'h5, 3'h4, 18'h00FA0, 1'h1},
    '{2'h2, 4'h6, 3'h2, 18'h007D0, 1'h0}, '{2'h2, 4'h6, 3'h3, 18'h007D0, 1'h1},
    '{2'h3, 4'h0, 3'h7, 18'h1F380, 1'h0}, '{2'h3, 4'h3, 3'h0, 18'h0471C, 1'h0},
    '{2'h3, 4'h7, 3'h2, 18'h003E7, 1'h1}, '{2'h0, 4'h9, 3'h1, 18'h00100, 1'h0},
    '{2'h1, 4'hA, 3'h1, 18'h0007D, 1'h0}, '{2'h0, 4'hF, 3'h2, 18'h00080, 1'h1},
    '{2'h3, 4'h1, 3'h7, 18'h14000, 1'h0}, '{2'h3, 4'h8, 3'h1, 18'h001F4, 1'h0},
    '{2'h3, 4'h9, 3'h0, 18'h000FA, 1'h0}, '{2'h3, 4'hC, 3'h2, 18'h0007D, 1'h1},
    '{2'h2, 4'h3, 3'h7, 18'h04574, 1'h0}, '{2'h3, 4'h4, 3'h7, 18'h01F38, 1'h1}};
  // clock
  always #4 pclk = ~pclk;
  drive_cfg dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .drive_setting,
    .combo_unsupported, .resync_pulse, .imp_cfg_changed);
  // verdict and end of run
  task automatic conclude;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, result in rd and err
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n >= 16) begin
      fails++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h1, LC_CFG_ADDR, 32'h0080_0000);
    foreach (rows[i]) begin
      apb(1'h1, CTRL_ADDR, {30'h0, rows[i].ms});
      apb(1'h1, IMP_CFG_ADDR, {20'h0, rows[i].fc, 1'h0, rows[i].mg, 4'h0});
      repeat (2) @(posedge pclk);
      chk(drive_setting.mod_freq_hz, rows[i].hz);
      chk(combo_unsupported, rows[i].bad);
      chk(drive_setting.drv_mag, rows[i].mg);
    end
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, LC_CFG_ADDR, 32'h0);
    chk(rd, 32'h0000_0055);
    chk(err, 1'h0);
    apb(1'h1, LC_CFG_ADDR, 32'hFFFF_FFFF);
    apb(1'h0, LC_CFG_ADDR, 32'h0);
    chk(rd, 32'h0088_70FF);
    chk({drive_setting.high_range, drive_setting.doubler}, 2'h3);
    chk({drive_setting.cm_res, drive_setting.lc_mag}, 8'hFF);
    chk({drive_setting.load_on, drive_setting.load_kohm}, 12'hC05);
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, LC_CFG_ADDR, (32'(i) << 12) | 32'h0000_4000);
      repeat (2) @(posedge pclk);
      chk(drive_setting.load_kohm, kohm[i]);
      chk(drive_setting.load_on, 1'h1);
    end
    apb(1'h1, IMP_CFG_ADDR, 32'h0000_0020);
    repeat (2) @(posedge pclk);
    chk(combo_unsupported, 1'h1);
    apb(1'h0, LC_CFG_ADDR, 32'h0);
    chk(rd, 32'h0000_7000);
    apb(1'h0, IMP_CFG_ADDR, 32'h0);
    chk(rd, 32'h0000_0020);
    chk(imp_cfg_changed, 1'h1);
    apb(1'h1, CTRL_ADDR, 32'h0000_0100);
    @(negedge pclk);
    chk(resync_pulse, 1'h1);
    @(negedge pclk);
    chk({imp_cfg_changed, resync_pulse}, 2'h0);
    apb(1'h0, STATUS_ADDR, 32'h0);
    chk(rd, 32'h1);
    apb(1'h1, CTRL_ADDR, 32'h0000_0002);
    apb(1'h0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0000_0002);
    apb(1'h0, 12'h004, 32'h0);
    chk(err, 1'h1);
    chk(rd, 32'h0000_0000);
    conclude();
  end
endmodule : tb
